// File: hdl/pll_core_pkg.sv
/*
 * Shared constants for the integer-N divider and phase detector core:
 * APB register offsets, frequency word field positions, reset values,
 * prescaler terminal counts and the frequency register selector type.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
package pll_core_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FREQ_W = 20;
    localparam int M_W = 9;
    localparam int A_W = 4;
    localparam int R_W = 6;
    localparam int MODE_W = 8;
    localparam int PER_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FREQ_PRI = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FREQ_SEC = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FREQ_EE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STORE = 8'h18;

    // frequency word layout, bit i of the word is serial bit i
    localparam int POS_R5 = 0;
    localparam int POS_R4 = 1;
    localparam int POS_M8 = 2;
    localparam int POS_M7 = 3;
    localparam int POS_PB = 4;
    localparam int POS_M6 = 5;
    localparam int POS_R3 = 12;
    localparam int POS_A3 = 16;

    // control and mode fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_STORE_WR = 8;
    localparam int CTRL_STORE_LD = 9;
    localparam int MODE_PWRDN = 3;

    // reset values
    localparam logic [FREQ_W-1:0] FREQ_RST = 20'h0_0000;
    localparam logic [FREQ_W-1:0] STORE_RST = 20'h0_0000;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;

    // prescaler terminal counts: divide by 10 and by 11
    localparam int PRE_DIV_LOW = 10;
    localparam int PRE_DIV_HIGH = 11;
    localparam logic [3:0] PRE_LIMIT_LOW = 4'(PRE_DIV_LOW - 1);
    localparam logic [3:0] PRE_LIMIT_HIGH = 4'(PRE_DIV_HIGH - 1);

    typedef enum logic [1:0] {SEL_PRIMARY, SEL_SECONDARY, SEL_EE} freq_sel_t;

    function automatic logic [M_W-1:0] field_m(input logic [FREQ_W-1:0] w);
        logic [M_W-1:0] m;
        m = '0;
        m[8] = w[POS_M8];
        m[7] = w[POS_M7];
        for (int k = 0; k < 7; k++) begin
            m[6-k] = w[POS_M6+k];
        end
        return m;
    endfunction : field_m

    function automatic logic [A_W-1:0] field_a(input logic [FREQ_W-1:0] w);
        logic [A_W-1:0] a;
        a = '0;
        for (int k = 0; k < 4; k++) begin
            a[3-k] = w[POS_A3+k];
        end
        return a;
    endfunction : field_a

    function automatic logic [R_W-1:0] field_r(input logic [FREQ_W-1:0] w);
        logic [R_W-1:0] r;
        r = '0;
        r[5] = w[POS_R5];
        r[4] = w[POS_R4];
        for (int k = 0; k < 4; k++) begin
            r[3-k] = w[POS_R3+k];
        end
        return r;
    endfunction : field_r

endpackage : pll_core_pkg

// File: hdl/edge_sync.sv
/*
 * Two-flop synchroniser with rising edge detector for an asynchronous pin.
 * Assumes the pin stays high and low for at least two clock periods.
 */
module edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;

endmodule : edge_sync

// File: hdl/div_count.sv
/*
 * Programmable divider: emits done on the tick that completes limit+1 ticks.
 * Assumes tick is a one-cycle enable in the same clock domain.
 */
module div_count #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    output logic done
);
    logic [W-1:0] cnt_ff;

    // >= so a limit lowered mid-count cannot strand the counter
    assign done = tick && (cnt_ff >= limit);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (done) begin
            cnt_ff <= '0;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

endmodule : div_count

// File: hdl/pll_divider_pfd.sv
/*
 * Digital core of an integer-N synthesizer: 10/11 prescaler with swallow
 * counter, main counter, 6-bit reference counter and phase-frequency detector,
 * with three frequency registers, a 20-bit store and a mode register on APB.
 * Assumes vco_in and ref_in are asynchronous pins well below pclk/4.
 *
 */
module pll_divider_pfd #(
    parameter logic [pll_core_pkg::FREQ_W-1:0] STORE_INIT = pll_core_pkg::STORE_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pll_core_pkg::ADDR_W-1:0] paddr,
    input wire logic [pll_core_pkg::DATA_W-1:0] pwdata,
    output logic [pll_core_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vco_in,
    input wire logic ref_in,
    output logic pump_up_pulse_n,
    output logic pump_down_pulse_n,
    output logic [1:0] charge_pump_output,
    output logic lock_detect_en
);
    import pll_core_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [FREQ_W-1:0] freq_pri_ff;
    logic [FREQ_W-1:0] freq_sec_ff;
    logic [FREQ_W-1:0] freq_ee_ff;
    logic [FREQ_W-1:0] store_ff;
    logic [MODE_W-1:0] mode_ff;
    freq_sel_t sel_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic pump_up_n_ff;
    logic pump_down_n_ff;
    logic [1:0] cp_ff;
    logic lock_en_ff;
    logic [A_W-1:0] swallow_ff;

    // APB decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_ff;
    wire wr_en = access & pwrite;
    wire hit_pri = (paddr == OFS_FREQ_PRI);
    wire hit_sec = (paddr == OFS_FREQ_SEC);
    wire hit_ee = (paddr == OFS_FREQ_EE);
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_mode = (paddr == OFS_MODE);
    wire hit_status = (paddr == OFS_STATUS);
    wire hit_store = (paddr == OFS_STORE);
    wire mapped = hit_pri | hit_sec | hit_ee | hit_ctrl | hit_mode | hit_status | hit_store;
    wire [1:0] wr_sel = pwdata[CTRL_SEL_LSB +: 2];
    wire sel_legal = (wr_sel != 2'b11);
    wire store_wr = wr_en & hit_ctrl & pwdata[CTRL_STORE_WR];
    wire store_ld = wr_en & hit_ctrl & pwdata[CTRL_STORE_LD];

    // selected register and its fields
    wire [FREQ_W-1:0] cfg_word = (sel_ff == SEL_PRIMARY) ? freq_pri_ff :
                                 (sel_ff == SEL_SECONDARY) ? freq_sec_ff : freq_ee_ff;
    wire [M_W-1:0] m_val = field_m(cfg_word);
    wire [A_W-1:0] a_val = field_a(cfg_word);
    wire [R_W-1:0] r_val = field_r(cfg_word);
    wire prescaler_bypass_bit = cfg_word[POS_PB];
    wire powered = ~mode_ff[MODE_PWRDN];

    wire [DATA_W-1:0] status_word = {25'h0, lock_en_ff, pump_up_n_ff, pump_down_n_ff,
                                     prescaler_bypass_bit, powered, sel_ff};
    wire [DATA_W-1:0] rd_word = hit_pri ? {12'h0, freq_pri_ff} :
                                hit_sec ? {12'h0, freq_sec_ff} :
                                hit_ee ? {12'h0, freq_ee_ff} :
                                hit_ctrl ? {30'h0, sel_ff} :
                                hit_mode ? {24'h0, mode_ff} :
                                hit_status ? status_word :
                                hit_store ? {12'h0, store_ff} : 32'h0000_0000;

    // answer one cycle after setup, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~mapped;
            prdata_ff <= (setup & ~pwrite) ? rd_word : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_pri_ff <= FREQ_RST;
            freq_sec_ff <= FREQ_RST;
            freq_ee_ff <= FREQ_RST;
        end else begin
            if (wr_en & hit_pri) freq_pri_ff <= pwdata[FREQ_W-1:0];
            if (wr_en & hit_sec) freq_sec_ff <= pwdata[FREQ_W-1:0];
            if (store_ld) begin
                freq_ee_ff <= store_ff;
            end else if (wr_en & hit_ee) begin
                freq_ee_ff <= pwdata[FREQ_W-1:0];
            end
        end
    end

    // store and transfer register swap cleanly if both commands coincide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_ff <= STORE_INIT;
        end else if (store_wr) begin
            store_ff <= freq_ee_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= MODE_RST;
            sel_ff <= SEL_PRIMARY;
        end else begin
            if (wr_en & hit_mode) mode_ff <= pwdata[MODE_W-1:0];
            if (wr_en & hit_ctrl & sel_legal) sel_ff <= freq_sel_t'(wr_sel);
        end
    end

    // pins into pclk domain; rate limit is pclk/4, a simulation trade-off
    logic vco_rise;
    logic ref_rise;

    edge_sync u_vco_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin(vco_in),
        .rise(vco_rise)
    );

    edge_sync u_ref_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin(ref_in),
        .rise(ref_rise)
    );

    // main chain
    wire vco_tick = vco_rise & powered;
    wire pre_tick = vco_tick & ~prescaler_bypass_bit;
    wire use_high = (swallow_ff < a_val);
    wire [3:0] pre_limit = use_high ? PRE_LIMIT_HIGH : PRE_LIMIT_LOW;
    logic pre_done;
    logic fp_edge;

    div_count #(.W(4)) u_prescaler (
        .clk(pclk),
        .rst_n(presetn),
        .tick(pre_tick),
        .limit(pre_limit),
        .done(pre_done)
    );

    wire main_tick = prescaler_bypass_bit ? vco_tick : pre_done;

    div_count #(.W(M_W)) u_main (
        .clk(pclk),
        .rst_n(presetn),
        .tick(main_tick),
        .limit(m_val),
        .done(fp_edge)
    );

    // swallow idles in bypass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swallow_ff <= '0;
        end else if (fp_edge | prescaler_bypass_bit) begin
            swallow_ff <= '0;
        end else if (pre_done & use_high) begin
            swallow_ff <= swallow_ff + 1'b1;
        end
    end

    // reference chain; limit 0 gives one output per reference edge
    wire ref_tick = ref_rise & powered;
    logic fc_edge;

    div_count #(.W(R_W)) u_ref (
        .clk(pclk),
        .rst_n(presetn),
        .tick(ref_tick),
        .limit(r_val),
        .done(fc_edge)
    );

    // phase-frequency detector; a pending pulse lasts until the other edge
    wire up_set = ~pump_up_n_ff | fc_edge;
    wire dn_set = ~pump_down_n_ff | fp_edge;
    wire both_seen = up_set & dn_set;
    wire nxt_up_n = ~(up_set & ~both_seen & powered);
    wire nxt_down_n = ~(dn_set & ~both_seen & powered);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_up_n_ff <= 1'b1;
            pump_down_n_ff <= 1'b1;
            cp_ff <= 2'h0;
            lock_en_ff <= 1'b1;
        end else begin
            pump_up_n_ff <= nxt_up_n;
            pump_down_n_ff <= nxt_down_n;
            cp_ff <= {~nxt_up_n, ~nxt_down_n};
            lock_en_ff <= nxt_up_n & nxt_down_n;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pump_up_pulse_n = pump_up_n_ff;
    assign pump_down_pulse_n = pump_down_n_ff;
    assign charge_pump_output = cp_ff;
    assign lock_detect_en = lock_en_ff;

    // checking helpers: input edges per output period, config stability
    logic [PER_W-1:0] vco_per_ff;
    logic [PER_W-1:0] ref_per_ff;
    logic [FREQ_W+2:0] prev_cfg_ff;
    logic main_settled_ff;
    logic ref_settled_ff;
    wire [FREQ_W+2:0] cfg_key = {cfg_word, sel_ff, powered};
    wire cfg_changed = (cfg_key != prev_cfg_ff);
    wire [PER_W-1:0] exp_high = PER_W'(m_val) * 16'd10 + 16'd10 + PER_W'(a_val);
    wire [PER_W-1:0] exp_bypass = PER_W'(m_val) + 16'd1;
    wire [PER_W-1:0] exp_ref = PER_W'(r_val) + 16'd1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_per_ff <= '0;
            ref_per_ff <= '0;
            prev_cfg_ff <= '0;
            main_settled_ff <= 1'b0;
            ref_settled_ff <= 1'b0;
        end else begin
            prev_cfg_ff <= cfg_key;
            vco_per_ff <= fp_edge ? '0 : vco_per_ff + PER_W'(vco_tick);
            ref_per_ff <= fc_edge ? '0 : ref_per_ff + PER_W'(ref_tick);
            main_settled_ff <= cfg_changed ? 1'b0 : (main_settled_ff | fp_edge);
            ref_settled_ff <= cfg_changed ? 1'b0 : (ref_settled_ff | fc_edge);
        end
    end

    a_high_ratio: assert property (fp_edge && main_settled_ff && !cfg_changed && !prescaler_bypass_bit
        |-> (vco_per_ff + 16'd1) == exp_high)
        else $error("main period wrong in prescaler mode");

    a_bypass_ratio: assert property (fp_edge && main_settled_ff && !cfg_changed && prescaler_bypass_bit
        |-> (vco_per_ff + 16'd1) == exp_bypass)
        else $error("main period wrong in bypass mode");

    a_ref_ratio: assert property (fc_edge && ref_settled_ff && !cfg_changed
        |-> (ref_per_ff + 16'd1) == exp_ref)
        else $error("reference period wrong");

    // terminal count actually reached, not the limit that was asked for
    a_pre_modulus: assert property (pre_done |-> u_prescaler.cnt_ff == PRE_LIMIT_LOW
        || u_prescaler.cnt_ff == PRE_LIMIT_HIGH)
        else $error("prescaler divided by neither 10 nor 11");

    a_swallow_idle: assert property (prescaler_bypass_bit |=> swallow_ff == '0)
        else $error("swallow counter ran in bypass");

    a_down_lead: assert property (fp_edge && !fc_edge && pump_up_n_ff && powered
        |=> !pump_down_pulse_n && pump_up_pulse_n)
        else $error("main edge did not start pump-down");

    a_up_lead: assert property (fc_edge && !fp_edge && pump_down_n_ff && powered
        |=> !pump_up_pulse_n && pump_down_pulse_n)
        else $error("reference edge did not start pump-up");

    a_pulse_hold: assert property (!pump_down_pulse_n && !fc_edge && powered
        |=> !pump_down_pulse_n)
        else $error("pump-down ended before reference edge");

    a_both_clear: assert property (!pump_down_pulse_n && fc_edge |=> pump_down_pulse_n && pump_up_pulse_n)
        else $error("pumps not released after both edges");

    a_never_both: assert property (pump_up_pulse_n || pump_down_pulse_n)
        else $error("both pumps active");

    a_cp_lock: assert property (charge_pump_output == {!pump_up_pulse_n, !pump_down_pulse_n}
        && lock_detect_en == (pump_up_pulse_n && pump_down_pulse_n))
        else $error("charge pump or lock enable out of step");

    a_sel_one: assert property (sel_ff != freq_sel_t'(2'b11))
        else $error("illegal register selection");

    a_store_load: assert property (store_ld |=> freq_ee_ff == $past(store_ff))
        else $error("transfer register not loaded from store");

    a_mode_port: assert property (mode_ff != $past(mode_ff) |-> $past(wr_en && hit_mode))
        else $error("mode register changed without a port write");

endmodule : pll_divider_pfd

// File: dv/osc_source_model.sv
/*
 * Far-side model: vco and reference sources, one rising edge per call.
 * Assumes pclk runs far faster than the pins; both pins idle low.
 */
module osc_source_model (
    input wire logic pclk,
    output logic vco_in,
    output logic ref_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        vco_in = 1'b0;
        ref_in = 1'b0;
    end

    // three cycles each way keeps the pins above the two-cycle minimum
    task automatic pulse(input logic use_vco);
        @(posedge pclk);
        if (use_vco) begin
            vco_in <= 1'b1;
        end else begin
            ref_in <= 1'b1;
        end
        repeat (3) @(posedge pclk);
        vco_in <= 1'b0;
        ref_in <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse
endmodule : osc_source_model

// File: dv/pll_divider_pfd_tb.sv
/*
 * Self-checking bench for pll_divider_pfd: register rows over apb, then
 * divider ratios, pump behaviour, selection, store and power down.
 * Assumes osc_source_model drives the vco and reference pins.
 */
module pll_divider_pfd_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pll_core_pkg::*;

    typedef struct {logic wr; logic [ADDR_W-1:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic vco_in, ref_in, pump_up_pulse_n, pump_down_pulse_n, lock_detect_en;
    logic [1:0] charge_pump_output;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int dn_low = 0;
    int dn_run = 0;

    // reset reads, 20-bit width, read-only store, unmapped address, select 3
    row_t rows [11] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h000FFFFF, 1'b0}, '{1'b1, 8'h18, 32'h12345, 32'h0, 1'b0},
        '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h0C, 32'h3, 32'h0, 1'b0},
        '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h1C, 32'h5, 32'h0, 1'b1}};

    pll_divider_pfd dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vco_in(vco_in), .ref_in(ref_in), .pump_up_pulse_n(pump_up_pulse_n),
        .pump_down_pulse_n(pump_down_pulse_n), .charge_pump_output(charge_pump_output),
        .lock_detect_en(lock_detect_en));

    osc_source_model src (.pclk(pclk), .vco_in(vco_in), .ref_in(ref_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // whole run needs well under this many cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            $display("CHECK FAILED %0t timeout", $time);
            end_of_test();
        end
    end

    // length of the last finished pump-down low run, in pclk edges
    always @(posedge pclk) begin
        if (pump_down_pulse_n === 1'b0) begin
            dn_low <= dn_low + 1;
        end else begin
            if (dn_low != 0) begin
                dn_run <= dn_low;
            end
            dn_low <= 0;
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic chk_cnt(input int got, input int exp, input string msg);
        checked++;
        if (got != exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask : chk_cnt

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] x;
        logic e;
        apb(1'b0, a, 32'h0, x, e);
        chk_word(x, exp, msg);
    endtask : rd_chk

    function automatic logic [31:0] fw(input int m, input int a, input int r, input logic pb);
        logic [8:0] mm;
        logic [3:0] aa;
        logic [5:0] rr;
        logic [31:0] w;
        mm = 9'(m);
        aa = 4'(a);
        rr = 6'(r);
        w = {12'h0, aa[0], aa[1], aa[2], aa[3], rr[0], rr[1], rr[2], rr[3],
             mm[0], mm[1], mm[2], mm[3], mm[4], mm[5], mm[6], pb, mm[7], mm[8], rr[4], rr[5]};
        return w;
    endfunction : fw

    function automatic logic [31:0] pins();
        return {27'h0, lock_detect_en, pump_up_pulse_n, pump_down_pulse_n, charge_pump_output};
    endfunction : pins

    // c: 0 down low, 1 up low, 2 both high
    function automatic logic hit(input int c);
        if (c == 2) begin
            return (pump_up_pulse_n & pump_down_pulse_n) === 1'b1;
        end
        return ((c == 1) ? pump_up_pulse_n : pump_down_pulse_n) === 1'b0;
    endfunction : hit

    task automatic run_to(input logic v, input int c, output int n);
        n = 0;
        while (!hit(c) && n < 300) begin
            src.pulse(v);
            n++;
        end
    endtask : run_to

    // early periods after a change may be irregular, so only the third counts;
    // a pending pulse only ends on the other pin's edge, so pulse that pin first
    task automatic meas(input logic v, output int n);
        repeat (3) begin
            run_to(pump_up_pulse_n === 1'b0, 2, n);
            run_to(v, v ? 0 : 1, n);
        end
    endtask : meas

    // down pump is low on entry; reference edge follows after k cycles
    task automatic width(input int k, output int w);
        repeat (k) @(posedge pclk);
        src.pulse(1'b0);
        w = dn_run;
    endtask : width

    initial begin
        logic [31:0] x;
        logic e;
        int n, w1, w2;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_word(pins(), 32'h1C, "reset pins");
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d, x, e);
            chk_word(rows[i].wr ? 32'h0 : x, rows[i].exp, "row read");
            chk_word({31'h0, e}, {31'h0, rows[i].err}, "row error");
        end
        wr(OFS_FREQ_PRI, fw(2, 3, 0, 1'b0));
        meas(1'b1, n);
        chk_cnt(n, 10 * (2 + 1) + 3, "high mode ratio");
        chk_word(pins(), 32'h09, "main leads");
        width(10, w1);
        chk_word(pins(), 32'h1C, "both seen");
        meas(1'b1, n);
        width(30, w2);
        chk_cnt(w2 - w1, 20, "width tracks offset");
        wr(OFS_FREQ_PRI, fw(1, 0, 0, 1'b0));
        meas(1'b1, n);
        chk_cnt(n, 20, "min main value");
        meas(1'b0, n);
        chk_cnt(n, 1, "reference undivided");
        chk_word(pins(), 32'h06, "reference leads");
        wr(OFS_FREQ_PRI, fw(1, 2, 0, 1'b0));
        meas(1'b1, n);
        chk_cnt(n, 22, "swallow at limit");
        wr(OFS_FREQ_SEC, fw(5, 0, 3, 1'b1));
        wr(OFS_CTRL, 32'h1);
        meas(1'b1, n);
        chk_cnt(n, 6, "bypass ratio");
        meas(1'b0, n);
        chk_cnt(n, 4, "reference ratio");
        wr(OFS_FREQ_EE, fw(3, 1, 0, 1'b1));
        wr(OFS_CTRL, 32'h101);
        rd_chk(OFS_STORE, fw(3, 1, 0, 1'b1), "store written");
        wr(OFS_MODE, 32'h40);
        wr(OFS_FREQ_EE, 32'h0);
        wr(OFS_CTRL, 32'h201);
        rd_chk(OFS_FREQ_EE, fw(3, 1, 0, 1'b1), "store loaded");
        rd_chk(OFS_MODE, 32'h40, "mode kept");
        wr(OFS_CTRL, 32'h2);
        meas(1'b1, n);
        chk_cnt(n, 4, "transfer register ratio");
        wr(OFS_MODE, 32'h48);
        repeat (8) begin
            src.pulse(1'b1);
            src.pulse(1'b0);
        end
        chk_word(pins(), 32'h1C, "powered down pins");
        wr(OFS_MODE, 32'h0);
        end_of_test();
    end
endmodule : pll_divider_pfd_tb
